// file: logic/nvsrs_map.vh
// Notes on behaviour
// (R01) Device holds busy low through every store.
// (R02) Device stays disabled until busy returns high.
// (R03) Supply dip latches recall, run on recovery.
// (R04) Sequence opens with three fixed prefix reads.
// (R05) Fourth, fifth fixed reads; sixth picks command.
// (R06) Sixth read 0x8FC0 starts a store.
// (R07) Sixth read 0x4C63 starts a recall.
// (R08) Sixth read 0x8B45 disables power-loss save.
// (R09) Sixth read 0x4B46 enables power-loss save.
// (R10) Any intervening access aborts the sequence.
// (R11) Host issues steps as reads, write high.
// (R12) Only low sixteen address lines are compared.
// (R13) Store erases then programs nonvolatile cells.
// (R14) Device disabled for the store duration.
// (R15) Recall clears SRAM then copies, duration.
// (R16) Store after changing save enable state.
// (R17) Low supply blocks stores and writes.
// (R18) Held write suppressed until strobe falls.
// (R19) Hardware store skipped without prior write.
// (R20) Pulling busy low requests store after delay.
// (R21) Mismatch returns detector idle, prefix restarts.
`ifndef NVSRS_MAP_VH
`define NVSRS_MAP_VH
`define NVSRS_AW 19
`define NVSRS_DW 16
`define NVSRS_SEQ0 16'h4E38
`define NVSRS_SEQ1 16'hB1C7
`define NVSRS_SEQ2 16'h83E0
`define NVSRS_SEQ3 16'h7C1F
`define NVSRS_SEQ4 16'h703F
`define NVSRS_CMD_STORE 16'h8FC0
`define NVSRS_CMD_RECALL 16'h4C63
`define NVSRS_CMD_SAVE_OFF 16'h8B45
`define NVSRS_CMD_SAVE_ON 16'h4B46
`define NVSRS_OP_READ 3'h0
`define NVSRS_OP_WRITE 3'h1
`define NVSRS_OP_STORE 3'h2
`define NVSRS_OP_RECALL 3'h3
`define NVSRS_OP_SAVE_OFF 3'h4
`define NVSRS_OP_SAVE_ON 3'h5
`define NVSRS_OP_HW_STORE 3'h6
`define NVSRS_CLK_NS 5
`define NVSRS_CYC_NS 25
`define NVSRS_CYC_CLK ((`NVSRS_CYC_NS + `NVSRS_CLK_NS - 1) / `NVSRS_CLK_NS)
`define NVSRS_SETUP_CLK 2
`define NVSRS_HWREQ_NS 100
`define NVSRS_HWREQ_CLK ((`NVSRS_HWREQ_NS + `NVSRS_CLK_NS - 1) / `NVSRS_CLK_NS)
`define NVSRS_BUSY_TIMEOUT 32'd4000000
`define NVSRS_STORE_US 8
`define NVSRS_STORE_CLK (`NVSRS_STORE_US * 1000 / `NVSRS_CLK_NS)
`define NVSRS_RECALL_US 20
`define NVSRS_RECALL_CLK (`NVSRS_RECALL_US * 1000 / `NVSRS_CLK_NS)
`define NVSRS_PUREC_US 20000
`define NVSRS_PUREC_CLK (`NVSRS_PUREC_US * 1000 / `NVSRS_CLK_NS)
`endif

// file: logic/nvsrs_wait.v
`timescale 1ns/1ps
`include "nvsrs_map.vh"
// Down counter; done pulses one cycle when a loaded count expires.
module nvsrs_wait (
  // Clock and reset.
  input wire clk,
  input wire resetn,
  // Load side.
  input wire load,
  input wire [31:0] count,
  // Status.
  output reg busy,
  output reg done
);
  reg [31:0] cnt_reg;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 32'h0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        cnt_reg <= (count == 32'h0) ? 32'h1 : count;
        busy <= 1'b1;
      end else if (busy) begin
        if (cnt_reg == 32'h1) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        cnt_reg <= cnt_reg - 32'h1;
      end
    end
  end
endmodule

// file: logic/nvsrs_host.v
`timescale 1ns/1ps
`include "nvsrs_map.vh"
// Host controller that drives the memory pins and issues command sequences.
module nvsrs_host #(
  parameter STORE_CLK = `NVSRS_STORE_CLK,
  parameter RECALL_CLK = `NVSRS_RECALL_CLK,
  parameter PUREC_CLK = `NVSRS_PUREC_CLK,
  parameter BUSY_TIMEOUT = `NVSRS_BUSY_TIMEOUT
) (
  // Clock and reset.
  input wire clk,
  input wire resetn,
  // User command port.
  input wire req_valid,
  input wire [2:0] req_op,
  input wire [18:0] req_addr,
  input wire [15:0] req_wdata,
  output reg req_ready,
  output reg rsp_valid,
  output reg [15:0] rsp_rdata,
  output reg rsp_err,
  // Supply status.
  input wire supply_ok,
  output reg save_enabled,
  output reg dirty,
  // Memory pins.
  output reg chip_sel_n,
  output reg write_strobe_n,
  output reg out_strobe_n,
  output reg upper_byte_enable_n,
  output reg lower_byte_enable_n,
  output reg [18:0] mem_addr,
  input wire [15:0] dq_in,
  output reg [15:0] dq_out,
  output reg dq_oe,
  input wire store_busy_n_in,
  output reg store_busy_n_out,
  output reg store_busy_n_oe
);
  localparam S_IDLE = 7'h01;
  localparam S_SETUP = 7'h02;
  localparam S_STROBE = 7'h04;
  localparam S_GAP = 7'h08;
  localparam S_WAIT = 7'h10;
  localparam S_HWREQ = 7'h20;
  localparam S_BUSY = 7'h40;

  function [15:0] seq_addr;
    input [2:0] idx;
    input [2:0] op;
    begin
      case (idx)
        3'd0: seq_addr = `NVSRS_SEQ0; // [R04]
        3'd1: seq_addr = `NVSRS_SEQ1; // [R04]
        3'd2: seq_addr = `NVSRS_SEQ2; // [R04]
        3'd3: seq_addr = `NVSRS_SEQ3; // [R05]
        3'd4: seq_addr = `NVSRS_SEQ4; // [R05]
        default: begin
          case (op)
            `NVSRS_OP_STORE: seq_addr = `NVSRS_CMD_STORE; // [R06]
            `NVSRS_OP_RECALL: seq_addr = `NVSRS_CMD_RECALL; // [R07]
            `NVSRS_OP_SAVE_OFF: seq_addr = `NVSRS_CMD_SAVE_OFF; // [R08]
            default: seq_addr = `NVSRS_CMD_SAVE_ON; // [R09]
          endcase
        end
      endcase
    end
  endfunction

  function is_seq;
    input [2:0] op;
    begin
      is_seq = (op == `NVSRS_OP_STORE) || (op == `NVSRS_OP_RECALL) ||
        (op == `NVSRS_OP_SAVE_OFF) || (op == `NVSRS_OP_SAVE_ON);
    end
  endfunction

  reg [6:0] state_reg;
  reg [2:0] op_reg;
  reg [2:0] step_reg;
  reg [7:0] cnt_reg;
  reg [18:0] addr_reg;
  reg [15:0] wdata_reg;
  reg boot_reg;
  reg supply_q_reg;
  reg [31:0] bcnt_reg;
  reg wait_load;
  reg [31:0] wait_count;
  wire wait_busy;
  wire wait_done;

  nvsrs_wait u_wait (
    .clk(clk),
    .resetn(resetn),
    .load(wait_load),
    .count(wait_count),
    .busy(wait_busy),
    .done(wait_done)
  );

  always @* begin
    wait_load = 1'b0;
    wait_count = 32'h0;
    if (state_reg == S_GAP && step_reg == 3'd5) begin
      wait_load = (op_reg == `NVSRS_OP_STORE) ||
        (op_reg == `NVSRS_OP_RECALL);
      wait_count = (op_reg == `NVSRS_OP_STORE) ? STORE_CLK // [R14]
        : RECALL_CLK; // [R15]
    end else if (state_reg == S_IDLE && supply_ok && !supply_q_reg) begin
      wait_load = 1'b1;
      wait_count = PUREC_CLK; // [R03]
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= S_IDLE;
      op_reg <= `NVSRS_OP_READ;
      step_reg <= 3'd0;
      cnt_reg <= 8'h0;
      addr_reg <= 19'h0;
      wdata_reg <= 16'h0;
      boot_reg <= 1'b1;
      supply_q_reg <= 1'b0;
      bcnt_reg <= 32'h0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 16'h0;
      rsp_err <= 1'b0;
      save_enabled <= 1'b1; // [R16]
      dirty <= 1'b0;
      chip_sel_n <= 1'b1;
      write_strobe_n <= 1'b1;
      out_strobe_n <= 1'b1;
      upper_byte_enable_n <= 1'b1;
      lower_byte_enable_n <= 1'b1;
      mem_addr <= 19'h0;
      dq_out <= 16'h0;
      dq_oe <= 1'b0;
      store_busy_n_out <= 1'b1;
      store_busy_n_oe <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      supply_q_reg <= supply_ok;
      case (state_reg)
        S_IDLE: begin
          // Any supply dip means the device will recall on recovery.
          if (!supply_ok || wait_busy || wait_load) begin // [R03] [R17]
            req_ready <= 1'b0;
            if (!supply_ok)
              boot_reg <= 1'b1;
          end else if (!store_busy_n_in) begin
            req_ready <= 1'b0; // [R02]
          end else if (req_ready && req_valid) begin
            req_ready <= 1'b0;
            op_reg <= req_op;
            addr_reg <= req_addr;
            wdata_reg <= req_wdata;
            step_reg <= 3'd0;
            cnt_reg <= 8'h0;
            if (req_op == `NVSRS_OP_HW_STORE) begin
              store_busy_n_out <= 1'b0; // [R20]
              store_busy_n_oe <= 1'b1;
              state_reg <= S_HWREQ;
            end else begin
              // Each access starts from deselected strobes, so a
              // held write never spans a store or recall.
              mem_addr <= is_seq(req_op) ? {3'h0, seq_addr(3'd0, req_op)}
                : req_addr; // [R12]
              state_reg <= S_SETUP; // [R18]
            end
          end else begin
            if (boot_reg)
              dirty <= 1'b0;
            boot_reg <= 1'b0;
            req_ready <= 1'b1;
          end
        end
        S_SETUP: begin
          cnt_reg <= cnt_reg + 8'h1;
          if (cnt_reg == `NVSRS_SETUP_CLK - 1) begin
            cnt_reg <= 8'h0;
            chip_sel_n <= 1'b0;
            if (op_reg == `NVSRS_OP_WRITE) begin
              write_strobe_n <= 1'b0;
              dq_out <= wdata_reg;
              dq_oe <= 1'b1;
            end else begin
              write_strobe_n <= 1'b1; // [R11]
              out_strobe_n <= 1'b0;
            end
            upper_byte_enable_n <= 1'b0;
            lower_byte_enable_n <= 1'b0;
            state_reg <= S_STROBE;
          end
        end
        S_STROBE: begin
          cnt_reg <= cnt_reg + 8'h1;
          if (cnt_reg == `NVSRS_CYC_CLK - 1) begin
            cnt_reg <= 8'h0;
            rsp_rdata <= (op_reg == `NVSRS_OP_WRITE) ? rsp_rdata : dq_in;
            chip_sel_n <= 1'b1;
            write_strobe_n <= 1'b1;
            out_strobe_n <= 1'b1;
            upper_byte_enable_n <= 1'b1;
            lower_byte_enable_n <= 1'b1;
            dq_oe <= 1'b0;
            state_reg <= S_GAP;
          end
        end
        S_GAP: begin
          // Steps follow back to back with no other access between.
          if (is_seq(op_reg) && step_reg != 3'd5) begin // [R10]
            step_reg <= step_reg + 3'd1;
            mem_addr <= {3'h0, seq_addr(step_reg + 3'd1, op_reg)}; // [R12]
            state_reg <= S_SETUP;
          end else begin
            if (op_reg == `NVSRS_OP_WRITE)
              dirty <= 1'b1;
            if (op_reg == `NVSRS_OP_SAVE_OFF)
              save_enabled <= 1'b0; // [R08] [R16]
            if (op_reg == `NVSRS_OP_SAVE_ON)
              save_enabled <= 1'b1; // [R09]
            if (op_reg == `NVSRS_OP_STORE || op_reg == `NVSRS_OP_RECALL) begin
              state_reg <= S_WAIT; // [R13] [R14] [R15]
            end else begin
              rsp_valid <= 1'b1;
              rsp_err <= 1'b0;
              state_reg <= S_IDLE;
            end
          end
        end
        S_WAIT: begin
          if (wait_done) begin
            dirty <= 1'b0;
            bcnt_reg <= 32'h0;
            state_reg <= S_BUSY; // [R01]
          end
        end
        S_HWREQ: begin
          cnt_reg <= cnt_reg + 8'h1;
          if (cnt_reg == `NVSRS_HWREQ_CLK - 1) begin
            cnt_reg <= 8'h0;
            store_busy_n_out <= 1'b1;
            store_busy_n_oe <= 1'b0;
            bcnt_reg <= 32'h0;
            // Without a write since the last store, no store runs.
            if (dirty)
              dirty <= 1'b0; // [R19]
            state_reg <= S_BUSY;
          end
        end
        S_BUSY: begin
          bcnt_reg <= bcnt_reg + 32'h1;
          if (store_busy_n_in) begin
            rsp_valid <= 1'b1; // [R01] [R02]
            rsp_err <= 1'b0;
            state_reg <= S_IDLE;
          end else if (bcnt_reg == BUSY_TIMEOUT) begin
            rsp_valid <= 1'b1;
            rsp_err <= 1'b1;
            state_reg <= S_IDLE;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// file: tb/nvsrs_chk.sv
`timescale 1ns/1ps
module nvsrs_chk (
  // Clock and reset.
  input wire clk,
  input wire resetn,
  // User port.
  input wire req_valid,
  input wire req_ready,
  input wire [2:0] req_op,
  input wire rsp_valid,
  // Memory pins.
  input wire chip_sel_n,
  input wire write_strobe_n,
  input wire out_strobe_n,
  input wire upper_byte_enable_n,
  input wire lower_byte_enable_n,
  input wire [18:0] mem_addr,
  input wire dq_oe,
  input wire store_busy_n_in,
  input wire store_busy_n_out,
  input wire store_busy_n_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence step(a);
    $fell(chip_sel_n) && mem_addr == {3'h0, a};
  endsequence
  AST_WE_SELECTED: assert property (!write_strobe_n |-> !chip_sel_n)
    else $error("write strobe without select");
  AST_NO_CONTENTION: assert property (
    !write_strobe_n |-> out_strobe_n && dq_oe)
    else $error("write strobe with output strobe or no data");
  AST_WORD_ACCESS: assert property (
    !chip_sel_n |-> !upper_byte_enable_n && !lower_byte_enable_n)
    else $error("byte enable high during access");
  AST_ADDR_HELD: assert property (
    !chip_sel_n && !$fell(chip_sel_n) |-> $stable(mem_addr))
    else $error("address moved during access");
  AST_STROBE_LEN: assert property (
    $fell(chip_sel_n) |-> (!chip_sel_n)[*5] ##1 chip_sel_n)
    else $error("select pulse length wrong");
  AST_RW_ANSWER: assert property (
    req_valid && req_ready && req_op <= 3'h1 |-> ##9 rsp_valid)
    else $error("access answer late or missing");
  AST_IDLE_WHILE_BUSY: assert property (
    $fell(chip_sel_n) |-> store_busy_n_in)
    else $error("access while busy low");
  AST_HW_PULL: assert property (
    store_busy_n_oe |-> !store_busy_n_out && chip_sel_n)
    else $error("busy request pulse malformed");
  AST_PREFIX: assert property (
    step(16'h4E38) ##8 step(16'hB1C7) |-> ##8 step(16'h83E0) ##8
    step(16'h7C1F) ##8 step(16'h703F))
    else $error("command prefix broken");
  cover property (step(16'h8FC0));
  cover property (step(16'h4C63));
  cover property (step(16'h8B45));
  cover property ($rose(store_busy_n_oe));
endmodule
bind nvsrs_host nvsrs_chk u_chk (.clk, .resetn, .req_valid, .req_ready,
  .req_op, .rsp_valid, .chip_sel_n, .write_strobe_n, .out_strobe_n,
  .upper_byte_enable_n, .lower_byte_enable_n, .mem_addr, .dq_oe,
  .store_busy_n_in, .store_busy_n_out, .store_busy_n_oe);

// file: tb/nvsrs_dev.sv
`timescale 1ns/1ps
module nvsrs_dev #(
  parameter STORE_NS = 300,
  parameter HWREQ_NS = 40
) (
  // Supply.
  input wire supply_ok,
  // Memory pins.
  input wire chip_sel_n,
  input wire write_strobe_n,
  input wire out_strobe_n,
  input wire [18:0] mem_addr,
  input wire [15:0] dq_wr,
  output wire [15:0] dq_rd,
  input wire busy_pin_n,
  output reg busy_drive,
  // Observation.
  output integer stores,
  output integer recalls,
  output reg save_on
);
  reg [15:0] mem [0:15];
  reg [15:0] nv [0:15];
  reg [15:0] seq [0:4];
  reg dirty, wr_seen, hold_wr;
  integer step, i;
  event do_store;
  wire [3:0] w = mem_addr[3:0];
  // Released or blocked outputs show the inverse of the word.
  assign dq_rd = (!chip_sel_n && !out_strobe_n && !busy_drive) ?
    mem[w] : ~mem[w];
  task recall_all;
    begin
      for (i = 0; i < 16; i = i + 1) mem[i] = 16'h0;
      for (i = 0; i < 16; i = i + 1) mem[i] = nv[i];
      recalls = recalls + 1;
      dirty = 1'b0;
      hold_wr = !chip_sel_n && !write_strobe_n;
    end
  endtask
  initial begin
    seq[0] = 16'h4E38;
    seq[1] = 16'hB1C7;
    seq[2] = 16'h83E0;
    seq[3] = 16'h7C1F;
    seq[4] = 16'h703F;
    for (i = 0; i < 16; i = i + 1) nv[i] = 16'h0;
    stores = 0;
    recalls = 0;
    save_on = 1'b1;
    dirty = 1'b0;
    busy_drive = 1'b0;
    wr_seen = 1'b0;
    step = 0;
    hold_wr = 1'b0;
  end
  always @(posedge supply_ok) recall_all;
  // A write held across power up, recall or store waits for a new edge.
  always @(negedge chip_sel_n or negedge write_strobe_n) begin
    hold_wr = 1'b0;
  end
  always @(chip_sel_n or write_strobe_n) begin
    if (!chip_sel_n && !write_strobe_n) wr_seen = 1'b1;
  end
  always @(posedge chip_sel_n) begin
    if (busy_drive) step = 0;
    else if (wr_seen) begin
      if (supply_ok && !hold_wr) mem[w] = dq_wr;
      dirty = 1'b1;
      step = 0;
    end else if (step == 5) begin
      step = 0;
      case (mem_addr[15:0])
        16'h8FC0: -> do_store;
        16'h4C63: recall_all;
        16'h8B45: save_on = 1'b0;
        16'h4B46: save_on = 1'b1;
        default: ;
      endcase
    end else if (mem_addr[15:0] == seq[step]) step = step + 1;
    else step = (mem_addr[15:0] == seq[0]) ? 1 : 0;
    wr_seen = 1'b0;
  end
  always @(do_store) begin
    busy_drive = 1'b1;
    #(STORE_NS);
    for (i = 0; i < 16; i = i + 1) nv[i] = 16'h0;
    for (i = 0; i < 16; i = i + 1) nv[i] = mem[i];
    stores = stores + 1;
    dirty = 1'b0;
    hold_wr = !chip_sel_n && !write_strobe_n;
    busy_drive = 1'b0;
  end
  always @(negedge busy_pin_n) begin
    if (!busy_drive) begin
      #(HWREQ_NS);
      if (dirty && supply_ok) -> do_store;
    end
  end
endmodule

// file: tb/nvsrs_host_bench.sv
`timescale 1ns/1ps
module nvsrs_host_bench;
  reg clk, resetn, req_valid, supply_ok;
  reg [2:0] req_op;
  reg [18:0] req_addr;
  reg [15:0] req_wdata;
  wire req_ready, rsp_valid, rsp_err, save_enabled, dirty, save_on;
  wire cs_n, we_n, oe_n, ube_n, lbe_n, dq_oe, bz_out, bz_oe, bz_drv;
  wire [15:0] rsp_rdata, dq_out, dq_rd, dq_in;
  wire [18:0] mem_addr;
  wire busy_pin_n;
  wire [31:0] stores, recalls;
  integer miscompares, tests_run;
  integer cyc = 0;
  // Busy pin has a pull-up; either party may pull it low.
  assign busy_pin_n = !(bz_oe || bz_drv);
  assign dq_in = dq_oe ? dq_out : dq_rd;
  nvsrs_host #(.STORE_CLK(20), .RECALL_CLK(20), .PUREC_CLK(20),
    .BUSY_TIMEOUT(200)) DUT (.clk(clk), .resetn(resetn),
    .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .rsp_err(rsp_err), .supply_ok(supply_ok),
    .save_enabled(save_enabled), .dirty(dirty), .chip_sel_n(cs_n),
    .write_strobe_n(we_n), .out_strobe_n(oe_n),
    .upper_byte_enable_n(ube_n), .lower_byte_enable_n(lbe_n),
    .mem_addr(mem_addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .store_busy_n_in(busy_pin_n), .store_busy_n_out(bz_out),
    .store_busy_n_oe(bz_oe));
  nvsrs_dev u_dev (.supply_ok(supply_ok), .chip_sel_n(cs_n),
    .write_strobe_n(we_n), .out_strobe_n(oe_n), .mem_addr(mem_addr),
    .dq_wr(dq_out), .dq_rd(dq_rd), .busy_pin_n(busy_pin_n),
    .busy_drive(bz_drv), .stores(stores), .recalls(recalls),
    .save_on(save_on));
  task final_report;
    begin
      if (miscompares == 0 && tests_run > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task check(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task do_req(input [2:0] op, input [18:0] a, input [15:0] d);
    integer n;
    begin
      n = 0;
      @(posedge clk);
      req_op <= op;
      req_addr <= a;
      req_wdata <= d;
      req_valid <= 1'b1;
      @(posedge clk);
      while (req_ready !== 1'b1) @(posedge clk);
      req_valid <= 1'b0;
      while (rsp_valid !== 1'b1 && n < 3000) begin
        @(posedge clk);
        n = n + 1;
      end
      check({n < 3000, rsp_err}, 2'b10);
    end
  endtask
  task t_rw;
    begin
      do_req(3'h1, 19'h00003, 16'h1234);
      do_req(3'h0, 19'h00003, 16'h0000);
      check(rsp_rdata, 16'h1234);
    end
  endtask
  task t_store_recall;
    integer s0, r0;
    begin
      s0 = stores;
      r0 = recalls;
      do_req(3'h1, 19'h00005, 16'hAAAA);
      do_req(3'h2, 19'h0, 16'h0);
      check(stores, s0 + 1);
      check(dirty, 0);
      do_req(3'h1, 19'h00005, 16'h5555);
      do_req(3'h3, 19'h0, 16'h0);
      check(recalls, r0 + 1);
      do_req(3'h0, 19'h00005, 16'h0);
      check(rsp_rdata, 16'hAAAA);
    end
  endtask
  task t_save;
    begin
      check({save_on, save_enabled}, 2'b11);
      do_req(3'h4, 19'h0, 16'h0);
      check({save_on, save_enabled}, 2'b00);
      do_req(3'h5, 19'h0, 16'h0);
      check({save_on, save_enabled}, 2'b11);
    end
  endtask
  task t_hw;
    integer s0;
    begin
      s0 = stores;
      do_req(3'h6, 19'h0, 16'h0);
      check(stores, s0);
      do_req(3'h1, 19'h00007, 16'h0001);
      do_req(3'h6, 19'h0, 16'h0);
      check(stores, s0 + 1);
    end
  endtask
  task t_supply;
    begin
      do_req(3'h1, 19'h00003, 16'hBEEF);
      supply_ok <= 1'b0;
      repeat (4) @(posedge clk);
      check(req_ready, 0);
      supply_ok <= 1'b1;
      do_req(3'h0, 19'h00003, 16'h0);
      check(rsp_rdata, 16'h1234);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      final_report;
    end
  end
  initial begin
    resetn = 1'b0;
    req_valid = 1'b0;
    req_op = 3'h0;
    req_addr = 19'h0;
    req_wdata = 16'h0;
    supply_ok = 1'b1;
    miscompares = 0;
    tests_run = 0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    t_rw;
    t_store_recall;
    t_save;
    t_hw;
    t_supply;
    final_report;
  end
endmodule
